/* core/bridge_fault_if.sv */
interface bridge_fault_if;
  import fault_prot_pkg::*;
  // settings and comparator levels toward the detector
  logic enable;
  logic gnd_disable;
  logic sup_disable;
  logic [1:0] filt_sel;
  logic delay_sel;
  logic gnd_raw;
  logic sup_raw;
  logic switch_evt;
  // verdicts back from the detector
  logic bridge_on;
  logic gnd_fault;
  logic sup_fault;

  modport ctrl (output enable, gnd_disable, sup_disable, filt_sel, delay_sel,
                gnd_raw, sup_raw, switch_evt, input bridge_on, gnd_fault, sup_fault);
  modport det (input enable, gnd_disable, sup_disable, filt_sel, delay_sel,
               gnd_raw, sup_raw, switch_evt, output bridge_on, gnd_fault, sup_fault);
endinterface

/* core/bridge_short_detect.sv */
module bridge_short_detect
  import fault_prot_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // one bridge
  bridge_fault_if.det bf
);

  typedef struct packed {
    det_state_e st;
    logic [CNT_W-1:0] cnt;
    logic [1:0] tries;
    logic on;
    logic gnd;
    logic sup;
  } det_s;

  det_s q;
  det_s d;

  // filter length for a select code
  function automatic logic [CNT_W-1:0] filt_len(input logic [1:0] sel);
    case (sel)
      2'h0: filt_len = CNT_W'(FILT0_CYC);
      2'h1: filt_len = CNT_W'(FILT1_CYC);
      2'h2: filt_len = CNT_W'(FILT2_CYC);
      default: filt_len = CNT_W'(FILT3_CYC);
    endcase
  endfunction

  logic gnd_act;
  logic sup_act;
  logic [CNT_W-1:0] blank_len;

  // disabled detectors never see a short
  assign gnd_act = bf.gnd_raw & ~bf.gnd_disable;
  assign sup_act = bf.sup_raw & ~bf.sup_disable;
  assign blank_len = bf.delay_sel ? CNT_W'(BLANK_HIGH_CYC - 1) : CNT_W'(BLANK_NORM_CYC - 1);

  // blank, filter, retry, lock
  always_comb begin
    d = q;
    case (q.st)
      DET_OFF: begin
        if (bf.enable) begin
          d.st = DET_BLANK;
          d.cnt = blank_len;
        end
      end
      DET_BLANK: begin
        if (q.cnt == '0) begin
          d.st = DET_WATCH;
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      DET_WATCH: begin
        if (bf.switch_evt) begin
          d.st = DET_BLANK; // blank over each switching edge
          d.cnt = blank_len;
        end else if (gnd_act | sup_act) begin
          if (q.cnt == filt_len(bf.filt_sel) - 1'b1) begin
            if (q.tries == SHORT_RETRIES) begin
              d.st = DET_LOCKED; // short persisted through retries
              d.gnd = gnd_act;
              d.sup = sup_act;
            end else begin
              d.st = DET_RETRY;
              d.tries = q.tries + 1'b1;
              d.cnt = CNT_W'(RETRY_OFF_CYC - 1);
            end
          end else begin
            d.cnt = q.cnt + 1'b1;
          end
        end else begin
          d.cnt = '0;
        end
      end
      DET_RETRY: begin
        if (q.cnt == '0) begin
          d.st = DET_BLANK;
          d.cnt = blank_len;
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      DET_LOCKED: d.st = DET_LOCKED; // held until re-enable
      default: d.st = DET_OFF;
    endcase
    // disable clears everything; the next enable restarts
    if (!bf.enable) begin
      d = '0;
      d.st = DET_OFF;
    end
    d.on = (d.st == DET_BLANK) || (d.st == DET_WATCH);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bf.bridge_on = q.on;
  assign bf.gnd_fault = q.gnd;
  assign bf.sup_fault = q.sup;
endmodule

/* core/driver_fault_protection.sv */
// Operation
// - Temperature is compared with a fixed pre-warning level and one of three shutdown levels.
// - After an overtemperature shutdown all bridges stay off until below pre-warning.
// - A detected short is retried three times before the bridge is locked off.
// - Ground shorts come from high-side drop, supply shorts from low-side plus sense drop.
// - The low-side short threshold takes values 4 to 15, 4 being most sensitive.
// - The high-side short threshold takes values 2 to 15, 2 being most sensitive.
// - Filter codes 0 to 3 give 100 ns, 1 us, 2 us, 3 us, code 1 after reset.
// - Detection is blanked 750 ns after switching, or 1500 ns when the delay bit is set.
// - The supply short disable bit turns low-side short protection off.
// - The ground short disable bit turns high-side short protection off.
// - A confirmed short turns off only its bridge and sets that bridge's own flag.
// - A per-coil open-load flag shows when coil current cannot be reached.
// - Open load is not evaluated at standstill.
// - Open-load flags are status only and never act on the bridges.
//
// Our own choices: the register addresses and the AXI4-Lite register port.
module driver_fault_protection
  import fault_prot_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,

  // axi4-lite write address
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,

  // axi4-lite write data
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,

  // axi4-lite write response
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,

  // axi4-lite read address
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,

  // axi4-lite read data
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,

  // temperature comparators: prewarn, 136, 143, 150
  input wire logic [3:0] TEMP_ABOVE,

  // short comparators per bridge (bit 0 = a)
  input wire logic [1:0] HS_DROP_HIGH,
  input wire logic [1:0] LS_DROP_HIGH,
  input wire logic [1:0] BRIDGE_SWITCH,

  // coil current supervision
  input wire logic [1:0] COIL_REACHED,
  input wire logic OL_SAMPLE,
  input wire logic STANDSTILL,

  // bridge control and comparator levels
  output logic [1:0] BRIDGE_ENABLE,
  output logic [3:0] LS_THRESHOLD,
  output logic [3:0] HS_THRESHOLD,
  output logic OVERTEMP_SHUTDOWN,
  output logic IRQ
);

  typedef struct packed {
    // bus side
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;

    // control and config
    logic drv_enable;
    logic [1:0] ot_sel;
    logic supply_short_disable;
    logic ground_short_disable;
    logic [3:0] lowside_short_threshold;
    logic [3:0] highside_short_threshold;
    logic [1:0] filt_sel;
    logic delay_sel;

    // status
    logic overtemp_shutdown_flag;
    logic [1:0] open_load;
    logic [EV_W-1:0] irq_stat;
    logic [EV_W-1:0] irq_mask;
    logic [EV_W-1:0] ev_prev;
    logic [1:0] bridge_en;
    logic irq;
  } top_s;

  top_s q;
  top_s d;

  // address compare on the word address
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  // byte-lane merge of a write into an old word
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                             input logic [DATA_W-1:0] wd,
                                             input logic [3:0] strb);
    logic [DATA_W-1:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  // clamp a threshold into its legal range
  function automatic logic [3:0] clamp(input logic [3:0] v, input logic [3:0] lo);
    clamp = (v < lo) ? lo : v;
  endfunction

  logic [1:0] det_on;
  logic [1:0] det_gnd;
  logic [1:0] det_sup;

  // one short detector per bridge
  for (genvar b = 0; b < 2; b++) begin : g_bridge
    bridge_fault_if bf ();
    assign bf.enable = q.drv_enable & ~q.overtemp_shutdown_flag;
    assign bf.gnd_disable = q.ground_short_disable;
    assign bf.sup_disable = q.supply_short_disable;
    assign bf.filt_sel = q.filt_sel;
    assign bf.delay_sel = q.delay_sel;
    assign bf.gnd_raw = HS_DROP_HIGH[b]; // high-side drop means ground short
    assign bf.sup_raw = LS_DROP_HIGH[b]; // low-side plus sense drop
    assign bf.switch_evt = BRIDGE_SWITCH[b];
    assign det_on[b] = bf.bridge_on;
    assign det_gnd[b] = bf.gnd_fault;
    assign det_sup[b] = bf.sup_fault;

    bridge_short_detect u_det (
      .clk(CORE_CLK),
      .rst(SYS_RST),
      .bf(bf)
    );
  end

  logic [3:0] wide_temp;
  logic ot_trip;
  logic [EV_W-1:0] ev_now;
  logic [EV_W-1:0] ev_rise;
  logic [DATA_W-1:0] ctrl_word;
  logic [DATA_W-1:0] cfg_word;
  logic [DATA_W-1:0] stat_word;
  logic [DATA_W-1:0] ctrl_new;
  logic [DATA_W-1:0] cfg_new;
  logic [DATA_W-1:0] mask_new;

  // shutdown level chosen among 136/143/150, code 3 acts as 150
  always_comb begin
    wide_temp = TEMP_ABOVE;
    case (q.ot_sel)
      2'h0: ot_trip = wide_temp[1];
      2'h1: ot_trip = wide_temp[2];
      default: ot_trip = wide_temp[3];
    endcase
  end

  // register images for readback
  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTRL_EN_BIT] = q.drv_enable;
    ctrl_word[CTRL_OTSEL_LSB +: 2] = q.ot_sel;
    ctrl_word[CTRL_SUPDIS_BIT] = q.supply_short_disable;
    ctrl_word[CTRL_GNDDIS_BIT] = q.ground_short_disable;
    cfg_word = '0;
    cfg_word[CFG_LS_LSB +: 4] = q.lowside_short_threshold;
    cfg_word[CFG_HS_LSB +: 4] = q.highside_short_threshold;
    cfg_word[CFG_FILT_LSB +: 2] = q.filt_sel;
    cfg_word[CFG_DELAY_BIT] = q.delay_sel;
    stat_word = '0;
    stat_word[EV_W-1:0] = ev_now;
    stat_word[ST_PREWARN_BIT] = TEMP_ABOVE[TEMP_PREWARN];
    stat_word[ST_TEMP_LSB +: 4] = TEMP_ABOVE;
    stat_word[ST_BRIDGE_LSB +: 2] = q.bridge_en;
  end

  // written words, byte lanes merged
  assign ctrl_new = merge(ctrl_word, q.w_data, q.w_strb);
  assign cfg_new = merge(cfg_word, q.w_data, q.w_strb);
  assign mask_new = merge(DATA_W'(q.irq_mask), q.w_data, q.w_strb);

  // event levels; their rising edges feed the sticky status
  always_comb begin
    ev_now = '0;
    ev_now[EV_OT] = q.overtemp_shutdown_flag;
    ev_now[EV_GND_A] = det_gnd[0];
    ev_now[EV_GND_B] = det_gnd[1];
    ev_now[EV_SUP_A] = det_sup[0];
    ev_now[EV_SUP_B] = det_sup[1];
    ev_now[EV_OL_A] = q.open_load[0];
    ev_now[EV_OL_B] = q.open_load[1];
    ev_rise = ev_now & ~q.ev_prev;
  end

  // bus slave, configuration, protection state
  always_comb begin
    d = q;
    d.ev_prev = ev_now;

    // overtemperature latch with hysteresis down to prewarn
    if (ot_trip) begin
      d.overtemp_shutdown_flag = 1'b1;
    end else if (!TEMP_ABOVE[TEMP_PREWARN]) begin
      d.overtemp_shutdown_flag = 1'b0;
    end

    // open load sampled once per chopper period, never at standstill
    if (OL_SAMPLE && !STANDSTILL && q.drv_enable) begin
      d.open_load = ~COIL_REACHED; // any cause of a missed current counts
    end

    // write channel: address and data taken in either order
    if (S_AXI_AWVALID && q.aw_rdy) begin
      d.aw_have = 1'b1;
      d.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && q.w_rdy) begin
      d.w_have = 1'b1;
      d.w_data = S_AXI_WDATA;
      d.w_strb = S_AXI_WSTRB;
    end
    if (q.aw_have && q.w_have) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = 2'h0;
      if (hit(q.aw_addr, CTRL_OFS)) begin
        d.drv_enable = ctrl_new[CTRL_EN_BIT];
        d.ot_sel = ctrl_new[CTRL_OTSEL_LSB +: 2];
        d.supply_short_disable = ctrl_new[CTRL_SUPDIS_BIT];
        d.ground_short_disable = ctrl_new[CTRL_GNDDIS_BIT];
      end else if (hit(q.aw_addr, CFG_OFS)) begin
        d.lowside_short_threshold =
          clamp(cfg_new[CFG_LS_LSB +: 4], LS_THR_MIN);
        d.highside_short_threshold =
          clamp(cfg_new[CFG_HS_LSB +: 4], HS_THR_MIN);
        d.filt_sel = cfg_new[CFG_FILT_LSB +: 2];
        d.delay_sel = cfg_new[CFG_DELAY_BIT];
      end else if (hit(q.aw_addr, IRQ_MASK_OFS)) begin
        d.irq_mask = mask_new[EV_W-1:0];
      end else if (!hit(q.aw_addr, STAT_OFS) && !hit(q.aw_addr, IRQ_STAT_OFS)) begin
        d.bresp = 2'h2; // unmapped: slave error
      end
    end

    if (q.bvalid && S_AXI_BREADY) begin
      d.bvalid = 1'b0;
    end

    // read channel; a read of the irq status clears it
    if (q.rvalid && S_AXI_RREADY) begin
      d.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && q.ar_rdy) begin
      d.rvalid = 1'b1;
      d.rresp = 2'h0;
      d.rdata = '0;
      if (hit(S_AXI_ARADDR, CTRL_OFS)) begin
        d.rdata = ctrl_word;
      end else if (hit(S_AXI_ARADDR, CFG_OFS)) begin
        d.rdata = cfg_word;
      end else if (hit(S_AXI_ARADDR, STAT_OFS)) begin
        d.rdata = stat_word;
      end else if (hit(S_AXI_ARADDR, IRQ_STAT_OFS)) begin
        d.rdata[EV_W-1:0] = q.irq_stat;
        d.irq_stat = '0;
      end else if (hit(S_AXI_ARADDR, IRQ_MASK_OFS)) begin
        d.rdata[EV_W-1:0] = q.irq_mask;
      end else begin
        d.rresp = 2'h2;
      end
    end

    // readies kept in flops
    d.aw_rdy = ~d.aw_have & ~d.bvalid;
    d.w_rdy = ~d.w_have & ~d.bvalid;
    d.ar_rdy = ~d.rvalid;

    // a new event beats a clearing read in the same cycle
    d.irq_stat = d.irq_stat | ev_rise;
    d.irq = |(d.irq_stat & d.irq_mask);

    // bridge gating: overtemp kills both, a short only its own
    for (int b = 0; b < 2; b++) begin
      d.bridge_en[b] = d.drv_enable & ~d.overtemp_shutdown_flag & det_on[b];
    end

    // open load deliberately absent from the gating above
  end

  // single state register
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      q <= '0;
      q.lowside_short_threshold <= THR_RESET;
      q.highside_short_threshold <= THR_RESET;
      q.filt_sel <= FILT_RESET;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign S_AXI_AWREADY = q.aw_rdy;
  assign S_AXI_WREADY = q.w_rdy;
  assign S_AXI_BVALID = q.bvalid;
  assign S_AXI_BRESP = q.bresp;
  assign S_AXI_ARREADY = q.ar_rdy;
  assign S_AXI_RVALID = q.rvalid;
  assign S_AXI_RDATA = q.rdata;
  assign S_AXI_RRESP = q.rresp;
  assign BRIDGE_ENABLE = q.bridge_en;
  assign LS_THRESHOLD = q.lowside_short_threshold;
  assign HS_THRESHOLD = q.highside_short_threshold;
  assign OVERTEMP_SHUTDOWN = q.overtemp_shutdown_flag;
  assign IRQ = q.irq;
endmodule

/* core/fault_prot_pkg.sv */
package fault_prot_pkg;
  // clock rate and bus widths
  localparam int CLK_MHZ = 250;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 10;

  // spike filter times and their cycle counts (least times round up)
  localparam int FILT0_NS = 100;
  localparam int FILT1_NS = 1000;
  localparam int FILT2_NS = 2000;
  localparam int FILT3_NS = 3000;
  localparam int FILT0_CYC = (FILT0_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT1_CYC = (FILT1_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT2_CYC = (FILT2_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT3_CYC = (FILT3_NS * CLK_MHZ + 999) / 1000;
  // blanking after a bridge switches
  localparam int BLANK_NORM_NS = 750;
  localparam int BLANK_HIGH_NS = 1500;
  localparam int BLANK_NORM_CYC = (BLANK_NORM_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK_HIGH_CYC = (BLANK_HIGH_NS * CLK_MHZ + 999) / 1000;
  // bridge off time between two tries
  localparam int RETRY_OFF_NS = 2000;
  localparam int RETRY_OFF_CYC = (RETRY_OFF_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0] SHORT_RETRIES = 2'h3;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] CFG_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h10;

  // control word fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_OTSEL_LSB = 1;
  localparam int CTRL_SUPDIS_BIT = 3;
  localparam int CTRL_GNDDIS_BIT = 4;
  // fault_detect_config fields
  localparam int CFG_LS_LSB = 0;
  localparam int CFG_HS_LSB = 8;
  localparam int CFG_FILT_LSB = 16;
  localparam int CFG_DELAY_BIT = 18;
  localparam logic [3:0] LS_THR_MIN = 4'h4;
  localparam logic [3:0] HS_THR_MIN = 4'h2;
  localparam logic [3:0] THR_RESET = 4'h6;
  localparam logic [1:0] FILT_RESET = 2'h1;

  // interrupt / status bit positions
  localparam int EV_OT = 0;
  localparam int EV_GND_A = 1;
  localparam int EV_GND_B = 2;
  localparam int EV_SUP_A = 3;
  localparam int EV_SUP_B = 4;
  localparam int EV_OL_A = 5;
  localparam int EV_OL_B = 6;
  localparam int EV_W = 7;
  localparam int ST_PREWARN_BIT = 7;
  localparam int ST_TEMP_LSB = 8;
  localparam int ST_BRIDGE_LSB = 12;

  // temperature comparator inputs: prewarn, 136, 143, 150
  localparam int TEMP_PREWARN = 0;

  typedef enum logic [2:0] {
    DET_OFF = 3'h0,
    DET_BLANK = 3'h1,
    DET_WATCH = 3'h3,
    DET_RETRY = 3'h2,
    DET_LOCKED = 3'h6
  } det_state_e;
endpackage

/* tb/fault_prot_properties.sv */
module fault_prot_properties
  import fault_prot_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // read handshake
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  // supervision
  input wire logic [3:0] TEMP_ABOVE,
  input wire logic [1:0] BRIDGE_ENABLE,
  input wire logic [3:0] LS_THRESHOLD,
  input wire logic [3:0] HS_THRESHOLD,
  input wire logic OVERTEMP_SHUTDOWN
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  // the top level trips whatever shutdown level is selected
  AST_OT_TOP: assert property (TEMP_ABOVE[3] && TEMP_ABOVE[0] |-> ##[1:2] OVERTEMP_SHUTDOWN)
    else $error("shutdown missed at top level");
  // hysteresis: flag holds while still above prewarn
  AST_OT_HOLD: assert property (OVERTEMP_SHUTDOWN && TEMP_ABOVE[0] |=> OVERTEMP_SHUTDOWN)
    else $error("shutdown released above prewarn");
  // two cycles below prewarn cover a registered comparator
  AST_OT_CLEAR: assert property (!TEMP_ABOVE[0] [*2] |=> !OVERTEMP_SHUTDOWN)
    else $error("shutdown kept below prewarn");
  AST_OT_OFF: assert property (OVERTEMP_SHUTDOWN [*3] |-> BRIDGE_ENABLE == 2'h0)
    else $error("bridge on during shutdown");
  AST_LS_RANGE: assert property (LS_THRESHOLD >= LS_THR_MIN)
    else $error("low side level below range");
  AST_HS_RANGE: assert property (HS_THRESHOLD >= HS_THR_MIN)
    else $error("high side level below range");
  // no short may trip bridge a in the first 8 cycles of its blanking
  AST_BLANK_A: assert property ($rose(BRIDGE_ENABLE[0]) |=> BRIDGE_ENABLE[0] [*8])
    else $error("bridge a dropped inside blanking");
  AST_AR_BLOCK: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read accepted while answer pending");
endmodule

/* tb/half_bridge_model.sv */
module half_bridge_model
  import fault_prot_pkg::*;
(
  // clock
  input wire logic clk,
  // bridge commands from the block
  input wire logic [1:0] bridge_on,
  // faults planted by the bench
  input wire logic [1:0] gnd_short,
  input wire logic [1:0] sup_short,
  input wire logic [1:0] open_coil,
  // comparator and current levels back
  output logic [1:0] hs_drop,
  output logic [1:0] ls_drop,
  output logic [1:0] switched,
  output logic [1:0] reached
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] on_q;
  // a short only shows a drop while its bridge conducts
  assign hs_drop = bridge_on & gnd_short;
  assign ls_drop = bridge_on & sup_short;
  // an open coil never reaches its current, whatever the cause
  assign reached = bridge_on & ~open_coil;
  // one pulse per turn-on, like a real switching edge
  always_ff @(posedge clk) on_q <= bridge_on;
  assign switched = bridge_on & ~on_q;
endmodule

/* tb/tb_driver_fault_protection.sv */
module tb_driver_fault_protection
  import fault_prot_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CORE_CLK, SYS_RST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic OL_SAMPLE, STANDSTILL, OVERTEMP_SHUTDOWN, IRQ;
  logic [ADDR_W-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [DATA_W-1:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB, TEMP_ABOVE, LS_THRESHOLD, HS_THRESHOLD;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, HS_DROP_HIGH, LS_DROP_HIGH, BRIDGE_SWITCH;
  logic [1:0] COIL_REACHED, BRIDGE_ENABLE, gnd_short, sup_short, open_coil;
  logic [31:0] rd_d;
  logic [1:0] rsp;
  int fail_count, tests_run, fa, fb, cyc, expc;
  localparam int filt_tab [4] = '{FILT0_CYC, FILT1_CYC, FILT2_CYC, FILT3_CYC};
  localparam logic [1:0] ot_sel_tab [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
  localparam logic [3:0] ot_temp_tab [5] = '{4'h3, 4'h3, 4'h7, 4'h7, 4'hf};
  localparam logic ot_exp_tab [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  driver_fault_protection driver_fault_protection_i (.CORE_CLK, .SYS_RST, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_AWADDR, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
    .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_ARADDR,
    .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA, .S_AXI_RRESP, .TEMP_ABOVE, .HS_DROP_HIGH,
    .LS_DROP_HIGH, .BRIDGE_SWITCH, .COIL_REACHED, .OL_SAMPLE, .STANDSTILL, .BRIDGE_ENABLE,
    .LS_THRESHOLD, .HS_THRESHOLD, .OVERTEMP_SHUTDOWN, .IRQ);
  half_bridge_model half_bridge_model_i (.clk(CORE_CLK), .bridge_on(BRIDGE_ENABLE), .gnd_short,
    .sup_short, .open_coil, .hs_drop(HS_DROP_HIGH), .ls_drop(LS_DROP_HIGH),
    .switched(BRIDGE_SWITCH), .reached(COIL_REACHED));

  // 250 mhz core clock
  initial begin
    CORE_CLK = 1'b0;
    forever #2 CORE_CLK = ~CORE_CLK;
  end

  task automatic bad(input string m);
    fail_count++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) bad($sformatf("word %h want %h", g, e));
  endtask
  task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
    tests_run++;
    if (g !== e) bad($sformatf("resp %h want %h", g, e));
  endtask
  // both channels offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_p, w_p;
    int n;
    aw_p = 1'b1;
    w_p = 1'b1;
    n = 0;
    @(posedge CORE_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    while ((aw_p || w_p || S_AXI_BVALID !== 1'b1) && n < 200) begin
      @(posedge CORE_CLK);
      n++;
      if (aw_p && S_AXI_AWREADY === 1'b1) begin
        aw_p = 1'b0;
        S_AXI_AWVALID <= 1'b0;
      end
      if (w_p && S_AXI_WREADY === 1'b1) begin
        w_p = 1'b0;
        S_AXI_WVALID <= 1'b0;
      end
    end
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
    if (n >= 200) bad("write hang");
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_p;
    int n;
    ar_p = 1'b1;
    n = 0;
    @(posedge CORE_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    while ((ar_p || S_AXI_RVALID !== 1'b1) && n < 200) begin
      @(posedge CORE_CLK);
      n++;
      if (ar_p && S_AXI_ARREADY === 1'b1) begin
        ar_p = 1'b0;
        S_AXI_ARVALID <= 1'b0;
      end
    end
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
    if (n >= 200) bad("read hang");
  endtask
  task automatic wok(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rsp);
    chk_r(rsp, 2'h0);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd(a, rd_d, rsp);
    chk_r(rsp, 2'h0);
    chk_w(rd_d, e);
  endtask
  // counts bridge turn-offs over a fixed span
  task automatic watch(input int span, output int na, output int nb);
    logic [1:0] prev;
    na = 0;
    nb = 0;
    prev = BRIDGE_ENABLE;
    repeat (span) begin
      @(posedge CORE_CLK);
      na += int'(prev[0] & ~BRIDGE_ENABLE[0]);
      nb += int'(prev[1] & ~BRIDGE_ENABLE[1]);
      prev = BRIDGE_ENABLE;
    end
  endtask
  // cycles bridge b stays on before its first trip
  task automatic meas(output int c);
    int n;
    n = 0;
    c = 0;
    while (BRIDGE_ENABLE[1] !== 1'b1 && n < 50) begin
      @(posedge CORE_CLK);
      n++;
    end
    while (BRIDGE_ENABLE[1] === 1'b1 && c < 2000) begin
      @(posedge CORE_CLK);
      c++;
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // whole run is near 11k cycles; over five times that means a hang
  initial begin
    repeat (60000) @(posedge CORE_CLK);
    bad("watchdog expired");
    give_verdict();
  end

  initial begin
    {SYS_RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 6'h20;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = {16'h0, 32'h0, 4'hf};
    {TEMP_ABOVE, OL_SAMPLE, STANDSTILL, gnd_short, sup_short, open_coil} = 12'h0;
    repeat (8) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    rd_chk(CTRL_OFS, 32'h0);
    rd_chk(CFG_OFS, 32'h00010606);
    rd(8'h14, rd_d, rsp);
    chk_r(rsp, 2'h2);
    chk_w(rd_d, 32'h0);
    wr(8'h14, 32'h1, rsp);
    chk_r(rsp, 2'h2);
    // below-range levels clamp to the most sensitive code
    wok(CFG_OFS, 32'h00010000);
    rd_chk(CFG_OFS, 32'h00010204);
    chk_w({24'h0, HS_THRESHOLD, LS_THRESHOLD}, 32'h24);
    wok(CFG_OFS, 32'h00010f0f);
    chk_w({24'h0, HS_THRESHOLD, LS_THRESHOLD}, 32'hff);
    // every filter code, both blanking settings, supply short on b
    for (int i = 0; i < 4; i++) begin
      wok(CFG_OFS, 32'h0606 | (32'(i) << 16) | (32'(i & 1) << 18));
      expc = ((i & 1) != 0 ? BLANK_HIGH_CYC : BLANK_NORM_CYC) + filt_tab[i];
      sup_short <= 2'b10;
      wok(CTRL_OFS, 32'h1);
      meas(cyc);
      chk_w(32'(cyc >= expc && cyc <= expc + 8), 32'h1);
      wok(CTRL_OFS, 32'h0);
      sup_short <= 2'b00;
    end
    // each disable bit hides its own short
    for (int i = 0; i < 2; i++) begin
      gnd_short <= i == 0 ? 2'b01 : 2'b00;
      sup_short <= i == 1 ? 2'b01 : 2'b00;
      wok(CTRL_OFS, i == 0 ? 32'h11 : 32'h09);
      watch(1200, fa, fb);
      chk_w(32'(fa), 32'h0);
      wok(CTRL_OFS, 32'h0);
    end
    // persistent ground short on a: three retries then lock
    {gnd_short, sup_short} <= 4'h4;
    wok(CFG_OFS, 32'h00010606);
    wok(IRQ_MASK_OFS, 32'h2);
    wok(CTRL_OFS, 32'h1);
    watch(5000, fa, fb);
    chk_w(32'(fa), 32'h4);
    chk_w(32'(fb), 32'h0);
    chk_w({31'h0, IRQ}, 32'h1);
    rd_chk(STAT_OFS, 32'h00002002);
    watch(1000, fa, fb);
    chk_w({30'h0, BRIDGE_ENABLE}, 32'h2);
    rd_chk(IRQ_STAT_OFS, 32'h2);
    rd_chk(IRQ_STAT_OFS, 32'h0);
    chk_w({31'h0, IRQ}, 32'h0);
    // restart by disable then enable
    gnd_short <= 2'b00;
    wok(CTRL_OFS, 32'h0);
    wok(CTRL_OFS, 32'h1);
    repeat (4) @(posedge CORE_CLK);
    chk_w({30'h0, BRIDGE_ENABLE}, 32'h3);
    rd_chk(STAT_OFS, 32'h00003000);
    // open coil a: ignored at standstill, masked from the irq line
    STANDSTILL <= 1'b1;
    open_coil <= 2'b01;
    for (int i = 0; i < 2; i++) begin
      @(posedge CORE_CLK);
      OL_SAMPLE <= 1'b1;
      @(posedge CORE_CLK);
      OL_SAMPLE <= 1'b0;
      rd_chk(STAT_OFS, i == 0 ? 32'h3000 : 32'h3020);
      STANDSTILL <= 1'b0;
    end
    chk_w({30'h0, BRIDGE_ENABLE}, 32'h3);
    chk_w({31'h0, IRQ}, 32'h0);
    rd_chk(IRQ_STAT_OFS, 32'h20);
    // each shutdown level, then hysteresis down to prewarn
    for (int i = 0; i < 5; i++) begin
      wok(CTRL_OFS, 32'h1 | (32'(ot_sel_tab[i]) << 1));
      TEMP_ABOVE <= ot_temp_tab[i];
      repeat (8) @(posedge CORE_CLK);
      chk_w({31'h0, OVERTEMP_SHUTDOWN}, 32'(ot_exp_tab[i]));
      TEMP_ABOVE <= 4'h1;
      repeat (8) @(posedge CORE_CLK);
      chk_w({31'h0, OVERTEMP_SHUTDOWN}, 32'(ot_exp_tab[i]));
      chk_w({30'h0, BRIDGE_ENABLE}, ot_exp_tab[i] ? 32'h0 : 32'h3);
      TEMP_ABOVE <= 4'h0;
      repeat (8) @(posedge CORE_CLK);
      chk_w({31'h0, OVERTEMP_SHUTDOWN}, 32'h0);
    end
    give_verdict();
  end
endmodule

bind driver_fault_protection fault_prot_properties fault_prot_properties_i (.CORE_CLK,
  .SYS_RST, .S_AXI_ARREADY, .S_AXI_RVALID, .TEMP_ABOVE, .BRIDGE_ENABLE, .LS_THRESHOLD,
  .HS_THRESHOLD, .OVERTEMP_SHUTDOWN);
